//--- verilog/cpu_reset_and_interrupt_accept.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_and_interrupt_accept
  import cpu_reset_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_rd,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic fetch_en,
  output logic [23:0] fetch_addr,
  output logic fetch_internal,
  input wire logic [7:0] irq_lines,
  input wire logic nmi_line,
  input wire logic [1:0] op_kind,
  input wire logic [2:0] op_arg,
  input wire logic sw_trap,
  input wire logic [2:0] sw_trap_num,
  input wire logic illegal_op,
  output logic irq_ack,
  output logic [7:0] irq_ack_vector,
  output logic [2:0] irq_ack_level,
  input wire logic ext_access,
  input wire logic [2:0] ext_area,
  output logic ext_width16,
  output logic ext_hi_data_en,
  output logic [7:0] port_mode,
  output logic io_reset,
  output logic clk_out,
  output logic dma_start,
  output logic [1:0] dma_channel,
  output logic [1:0] dma_unit
);

  core_state_type state_q;
  logic [23:0] pc_q;
  logic [31:0] sp_q;
  logic [2:0] mask_q;
  logic max_q;
  logic [2:0] bank_q;
  logic [23:0] levels_q;
  logic [8:0] pending_q;
  logic [4:0] busw_q;
  logic [7:0] portmode_q;
  logic [23:0] load_base_q;
  logic [1:0] issue_cnt_q;
  logic [1:0] cap_cnt_q;
  logic cap_valid_q;
  logic cap_dly_q;
  logic [7:0] last_vector_q;
  logic [1:0] div_cnt_q;
  logic [31:0] scratch_q;

  logic [2:0] best_level;
  logic [3:0] best_src;
  logic best_valid;
  logic [2:0] mask_eff;
  logic take_hw;
  logic take_trap;
  logic [7:0] take_vector;
  logic [15:0] status_word;
  logic [31:0] rdata_d;

  function automatic logic [2:0] src_level(input logic [23:0] lv, input int idx);
    if (idx == NMI_INDEX) begin
      return MASK_TOP;
    end
    return lv[idx*3 +: 3];
  endfunction

  function automatic logic [7:0] src_vector(input int idx);
    if (idx == NMI_INDEX) begin
      return VEC_NMI;
    end
    return VEC_MASKABLE_BASE + 8'(idx << VEC_STEP_SHIFT);
  endfunction

  assign status_word = {1'b0, mask_q, max_q, bank_q, 8'h00};

  // highest level wins; on equal levels the lower index wins (the smaller vector, except the NMI at index 8 with vector 20h)
  always_comb begin
    best_level = 3'h0;
    best_src = 4'h0;
    best_valid = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (pending_q[i] && src_level(levels_q, i) != 3'h0 &&
          (!best_valid || src_level(levels_q, i) > best_level)) begin
        best_level = src_level(levels_q, i);
        best_src = 4'(i);
        best_valid = 1'b1;
      end
    end
  end

  // the enable op's new mask already gates acceptance in its own cycle
  always_comb begin
    mask_eff = mask_q;
    if (op_kind == OP_EI) begin
      mask_eff = (op_arg == 3'h0) ? MASK_EI_FLOOR : op_arg;
    end else if (op_kind == OP_DI) begin
      mask_eff = MASK_TOP;
    end
  end

  assign take_trap = (state_q == ST_RUN) && (sw_trap || illegal_op);
  assign take_hw = (state_q == ST_RUN) && !take_trap && best_valid &&
                   (best_level > mask_eff);

  always_comb begin
    if (illegal_op) begin
      take_vector = VEC_ILLEGAL;
    end else if (sw_trap) begin
      take_vector = VEC_TRAP_BASE + 8'({sw_trap_num, 2'b00});
    end else begin
      take_vector = src_vector(int'(best_src));
    end
  end

  // sequencer: reset hold, three-byte vector load, run
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_HOLD;
      load_base_q <= VECTOR_BASE;
      issue_cnt_q <= 2'h0;
      cap_cnt_q <= 2'h0;
      cap_valid_q <= 1'b0;
      cap_dly_q <= 1'b0;
    end else begin
      cap_valid_q <= 1'b0;
      // the byte of a read stands one cycle after mem_rd, so capture one cycle later
      cap_dly_q <= cap_valid_q;
      unique case (state_q)
        ST_HOLD: begin
          state_q <= ST_LOAD;
          issue_cnt_q <= 2'h0;
          cap_cnt_q <= 2'h0;
        end
        ST_LOAD: begin
          if (issue_cnt_q != VECTOR_BYTES) begin
            issue_cnt_q <= issue_cnt_q + 2'h1;
            cap_valid_q <= 1'b1;
          end
          if (cap_dly_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == VECTOR_BYTES - 2'h1) begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (take_trap || take_hw) begin
            state_q <= ST_LOAD;
            load_base_q <= VECTOR_BASE + {16'h0000, take_vector};
            issue_cnt_q <= 2'h0;
            cap_cnt_q <= 2'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_rd <= 1'b0;
      mem_addr <= VECTOR_BASE;
    end else begin
      mem_rd <= (state_q == ST_LOAD) && (issue_cnt_q != VECTOR_BYTES);
      mem_addr <= load_base_q + {22'h000000, issue_cnt_q};
    end
  end

  // a byte arrives one cycle after its read; low byte first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_q <= 24'h000000;
    end else if (state_q == ST_LOAD && cap_dly_q) begin
      pc_q[cap_cnt_q*8 +: 8] <= mem_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fetch_en <= 1'b0;
      fetch_addr <= 24'h000000;
      fetch_internal <= 1'b1;
    end else begin
      fetch_en <= (state_q == ST_RUN) && !take_trap && !take_hw;
      fetch_addr <= pc_q;
      fetch_internal <= 1'b1;
    end
  end

  // status word fields; bus write first, op or acceptance overrides
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
      max_q <= MAX_RESET;
      bank_q <= BANK_RESET;
    end else begin
      if (reg_wr && reg_addr == REG_STATUS) begin
        max_q <= reg_wdata[SW_MAX_BIT]; // software keeps this at 1
        bank_q <= reg_wdata[SW_BANK_HI:SW_BANK_LO];
        mask_q <= reg_wdata[SW_MASK_HI:SW_MASK_LO];
      end
      if (op_kind == OP_EI || op_kind == OP_DI) begin
        mask_q <= mask_eff;
      end
      if (take_hw) begin
        mask_q <= (best_level == MASK_TOP) ? MASK_TOP : best_level + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sp_q <= SP_RESET;
    end else if (reg_wr && reg_addr == REG_SP) begin
      sp_q <= reg_wdata;
    end
  end

  // general core state left untouched by reset
  always_ff @(posedge mclk) begin
    if (reg_wr && reg_addr == REG_CORE) begin
      scratch_q <= reg_wdata;
    end
  end

  // pending flags: a new request wins over the clear from acknowledge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pending_q <= 9'h000;
    end else begin
      for (int i = 0; i < NUM_SOURCES; i++) begin
        if (take_hw && best_src == 4'(i)) begin
          pending_q[i] <= 1'b0;
        end
        if (i == NMI_INDEX ? nmi_line : irq_lines[i % NUM_MASKABLE]) begin
          pending_q[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      irq_ack_vector <= 8'h00;
      irq_ack_level <= 3'h0;
      last_vector_q <= 8'h00;
    end else begin
      irq_ack <= take_hw || take_trap;
      if (take_hw || take_trap) begin
        irq_ack_vector <= take_vector;
        irq_ack_level <= take_hw ? best_level : 3'h0;
        last_vector_q <= take_vector;
      end
    end
  end

  // internal I/O registers go back to defaults under reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      levels_q <= LEVELS_RESET;
      busw_q <= BUSW_RESET;
      portmode_q <= PORTMODE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_LEVELS) begin
        levels_q <= reg_wdata[23:0];
      end
      if (reg_addr == REG_BUSW) begin
        busw_q <= reg_wdata[4:0];
      end
      if (reg_addr == REG_PORTMODE) begin
        portmode_q <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_reset <= 1'b1;
      port_mode <= PORTMODE_RESET;
    end else begin
      io_reset <= 1'b0;
      port_mode <= portmode_q;
    end
  end

  // areas 0..3 use their own bit, anything else the default-area bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_width16 <= 1'b0;
      ext_hi_data_en <= 1'b0;
    end else begin
      ext_width16 <= ext_access &&
                     (ext_area < 3'h4 ? busw_q[ext_area[1:0]] : busw_q[4]);
      ext_hi_data_en <= portmode_q[PORT1_DATA_BIT];
    end
  end

  // clock out is a divide-by-four square wave, held high through reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt_q <= 2'h0;
      clk_out <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      clk_out <= ~div_cnt_q[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dma_start <= 1'b0;
      dma_channel <= 2'h0;
      dma_unit <= 2'h0;
    end else begin
      dma_start <= reg_wr && reg_addr == REG_DMASTART && reg_wdata[3:2] != 2'h3;
      if (reg_wr && reg_addr == REG_DMASTART) begin
        dma_channel <= reg_wdata[1:0];
        dma_unit <= reg_wdata[3:2];
      end
    end
  end

  always_comb begin
    unique case (reg_addr)
      REG_STATUS: rdata_d = {16'h0000, status_word};
      REG_PC: rdata_d = {8'h00, pc_q};
      REG_SP: rdata_d = sp_q;
      REG_LEVELS: rdata_d = {8'h00, levels_q};
      REG_PENDING: rdata_d = {23'h000000, pending_q};
      REG_BUSW: rdata_d = {27'h0000000, busw_q};
      REG_PORTMODE: rdata_d = {24'h000000, portmode_q};
      REG_CORE: rdata_d = {22'h000000, state_q, last_vector_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

//--- verilog/cpu_reset_irq_pkg.sv
package cpu_reset_irq_pkg;

  localparam int MCLK_HZ = 10_000_000;
  localparam int RESET_HOLD_CLOCKS = 10;

  // core reset values
  localparam logic [23:0] VECTOR_BASE = 24'hffff00;
  localparam logic [1:0] VECTOR_BYTES = 2'h3;
  localparam logic [31:0] SP_RESET = 32'h00000100;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [2:0] MASK_TOP = 3'h7;
  localparam logic [2:0] MASK_EI_FLOOR = 3'h1;
  localparam logic MAX_RESET = 1'h1;
  localparam logic [2:0] BANK_RESET = 3'h0;

  // status word layout
  localparam int SW_MASK_HI = 14;
  localparam int SW_MASK_LO = 12;
  localparam int SW_MAX_BIT = 11;
  localparam int SW_BANK_HI = 10;
  localparam int SW_BANK_LO = 8;

  // interrupt sources: maskable lines 0..7, one NMI line at level 7, which a mask of 7 also holds off
  localparam int NUM_MASKABLE = 8;
  localparam int NUM_SOURCES = 9;
  localparam int NMI_INDEX = 8;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h00;
  localparam logic [7:0] VEC_ILLEGAL = 8'h08;
  localparam logic [7:0] VEC_NMI = 8'h20;
  localparam logic [7:0] VEC_MASKABLE_BASE = 8'h28;
  localparam int VEC_STEP_SHIFT = 2;

  // register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PC = 8'h04;
  localparam logic [7:0] REG_SP = 8'h08;
  localparam logic [7:0] REG_LEVELS = 8'h0c;
  localparam logic [7:0] REG_PENDING = 8'h10;
  localparam logic [7:0] REG_BUSW = 8'h14;
  localparam logic [7:0] REG_PORTMODE = 8'h18;
  localparam logic [7:0] REG_DMASTART = 8'h1c;
  localparam logic [7:0] REG_CORE = 8'h20;

  localparam logic [23:0] LEVELS_RESET = 24'h000000;
  localparam logic [4:0] BUSW_RESET = 5'h00;
  localparam logic [7:0] PORTMODE_RESET = 8'h00;
  localparam int PORT1_DATA_BIT = 0;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_EI,
    OP_DI
  } op_type;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOAD,
    ST_RUN
  } core_state_type;

endpackage

//--- verification/vector_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module vector_rom_model (
  input wire logic mclk,
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr,
  output logic [7:0] mem_rdata
);
  initial mem_rdata = 8'h00;
  // data stand only in the cycle after the strobe; otherwise they toggle so stale bytes fail
  always @(posedge mclk) begin
    if (mem_rd) begin
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

//--- verification/irq_accept_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module irq_accept_checker
  import cpu_reset_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr,
  input wire logic fetch_en,
  input wire logic fetch_internal,
  input wire logic irq_ack,
  input wire logic [7:0] irq_ack_vector,
  input wire logic [2:0] irq_ack_level,
  input wire logic io_reset,
  input wire logic clk_out,
  input wire logic dma_start,
  input wire logic [1:0] dma_channel,
  input wire logic [1:0] dma_unit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_reset_outputs: assert property (disable iff (1'b0)
    (!rst_n ##1 !rst_n) |-> clk_out && io_reset && !fetch_en && !irq_ack && !mem_rd)
    else $error("reset outputs wrong");
  a_vector_fetch: assert property (
    $rose(rst_n) |-> ##[1:4] (mem_rd && mem_addr == VECTOR_BASE) ##1
    (mem_rd && mem_addr == VECTOR_BASE + 24'h1) ##1 (mem_rd && mem_addr == VECTOR_BASE + 24'h2))
    else $error("reset vector reads wrong");
  a_fetch_source: assert property (fetch_en |-> fetch_internal)
    else $error("fetch not internal");
  a_vector_jump: assert property (
    irq_ack |-> ##[0:6] (mem_rd && mem_addr == VECTOR_BASE + {16'h0, irq_ack_vector}))
    else $error("vector read missing");
  a_nmi_level: assert property (
    irq_ack && irq_ack_vector == VEC_NMI |-> irq_ack_level == 3'h7)
    else $error("nmi level wrong");
  a_trap_level: assert property (
    irq_ack && irq_ack_vector < VEC_NMI |-> irq_ack_level == 3'h0)
    else $error("trap level wrong");
  // mask drops below 1 only by a status write, and the tests' one status write sets it to 7, so a taken maskable level is at least 2
  a_hw_level: assert property (
    irq_ack && irq_ack_vector >= VEC_MASKABLE_BASE |-> irq_ack_level > 3'h1)
    else $error("maskable level too low");
  a_dma_start: assert property (
    reg_wr && reg_addr == REG_DMASTART && reg_wdata[3:2] != 2'h3 |=> dma_start &&
    dma_channel == $past(reg_wdata[1:0]) && dma_unit == $past(reg_wdata[3:2]))
    else $error("dma start wrong");
endmodule
bind cpu_reset_and_interrupt_accept irq_accept_checker u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .fetch_en(fetch_en), .fetch_internal(fetch_internal),
  .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector), .irq_ack_level(irq_ack_level),
  .io_reset(io_reset), .clk_out(clk_out), .dma_start(dma_start),
  .dma_channel(dma_channel), .dma_unit(dma_unit)
);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top
  import cpu_reset_irq_pkg::*;
;
  logic mclk, rst_n, reg_wr, reg_rd, nmi_line, sw_trap, illegal_op, ext_access, mem_rd;
  logic fetch_en, fetch_internal, irq_ack, ext_width16, ext_hi_data_en, io_reset, clk_out;
  logic dma_start;
  logic [7:0] reg_addr, irq_lines, mem_rdata, irq_ack_vector, port_mode;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] mem_addr, fetch_addr;
  logic [2:0] op_arg, sw_trap_num, ext_area, irq_ack_level;
  logic [1:0] op_kind, dma_channel, dma_unit;
  int error_cnt, cmp_count, cyc;
  cpu_reset_and_interrupt_accept u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
    .fetch_internal(fetch_internal), .irq_lines(irq_lines), .nmi_line(nmi_line),
    .op_kind(op_kind), .op_arg(op_arg), .sw_trap(sw_trap), .sw_trap_num(sw_trap_num),
    .illegal_op(illegal_op), .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector),
    .irq_ack_level(irq_ack_level), .ext_access(ext_access), .ext_area(ext_area),
    .ext_width16(ext_width16), .ext_hi_data_en(ext_hi_data_en), .port_mode(port_mode),
    .io_reset(io_reset), .clk_out(clk_out), .dma_start(dma_start),
    .dma_channel(dma_channel), .dma_unit(dma_unit)
  );
  vector_rom_model u_rom (
    .mclk(mclk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata)
  );
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 4000) begin
      error_cnt++;
      summarize();
    end
  end
  function automatic logic [23:0] pcv(input logic [7:0] v);
    return {(v + 8'h2) ^ 8'h5a, (v + 8'h1) ^ 8'h5a, v ^ 8'h5a};
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge mclk);
  endtask
  task automatic op(input op_type k, input logic [2:0] n);
    op_kind <= k;
    op_arg <= n;
    @(posedge mclk);
    op_kind <= OP_NONE;
  endtask
  task automatic pulse(input logic [7:0] l);
    irq_lines <= l;
    @(posedge mclk);
    irq_lines <= 8'h00;
  endtask
  task automatic no_ack(input int n);
    repeat (n) begin
      @(negedge mclk);
      `CHK("irq_ack", 1'b0, irq_ack)
    end
    @(posedge mclk);
  endtask
  task automatic wait_fetch(input logic [23:0] pc);
    int i;
    i = 0;
    @(negedge mclk);
    while (fetch_en !== 1'b1 && i < 20) begin
      @(negedge mclk);
      i++;
    end
    `CHK("fetch_en", 1'b1, fetch_en)
    `CHK("fetch_addr", pc, fetch_addr)
    `CHK("fetch_internal", 1'b1, fetch_internal)
    @(posedge mclk);
  endtask
  task automatic wait_ack(input logic [7:0] v, input logic [2:0] lv);
    int i;
    i = 0;
    @(negedge mclk);
    while (irq_ack !== 1'b1 && i < 20) begin
      @(negedge mclk);
      i++;
    end
    `CHK("irq_ack", 1'b1, irq_ack)
    `CHK("ack_vector", v, irq_ack_vector)
    `CHK("ack_level", lv, irq_ack_level)
    wait_fetch(pcv(v));
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (RESET_HOLD_CLOCKS) @(posedge mclk);
    @(negedge mclk);
    `CHK("clk_out", 1'b1, clk_out)
    `CHK("io_reset", 1'b1, io_reset)
    `CHK("port_mode", 8'h00, port_mode)
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_fetch(pcv(8'h00));
    rdchk(REG_STATUS, 32'h00007800);
    rdchk(REG_SP, 32'h00000100);
    rdchk(REG_PC, {8'h00, pcv(8'h00)});
    rdchk(8'h3c, 32'h00000000);
  endtask
  task automatic t_irq;
    wr(REG_LEVELS, 32'h000003ab);
    pulse(8'h01);
    no_ack(8);
    op(OP_EI, 3'h3);
    no_ack(6);
    op(OP_EI, 3'h2);
    wait_ack(8'h28, 3'h3);
    rdchk(REG_STATUS, 32'h00004800);
  endtask
  task automatic t_prio;
    op(OP_DI, 3'h0);
    pulse(8'h0e);
    op(OP_EI, 3'h0);
    wait_ack(8'h30, 3'h6);
    rdchk(REG_STATUS, 32'h00007800);
    op(OP_EI, 3'h0);
    wait_ack(8'h2c, 3'h5);
    op(OP_EI, 3'h0);
    no_ack(6);
    rdchk(REG_STATUS, 32'h00001800);
    op(OP_DI, 3'h0);
    rdchk(REG_STATUS, 32'h00007800);
  endtask
  task automatic t_exc;
    nmi_line <= 1'b1;
    @(posedge mclk);
    nmi_line <= 1'b0;
    no_ack(4);
    op(OP_EI, 3'h6);
    wait_ack(8'h20, 3'h7);
    sw_trap <= 1'b1;
    sw_trap_num <= 3'h3;
    @(posedge mclk);
    sw_trap <= 1'b0;
    wait_ack(8'h0c, 3'h0);
    illegal_op <= 1'b1;
    @(posedge mclk);
    illegal_op <= 1'b0;
    wait_ack(8'h08, 3'h0);
    rdchk(REG_STATUS, 32'h00007800);
  endtask
  task automatic t_io;
    for (int u = 0; u < 3; u++) begin
      wr(REG_DMASTART, 32'(u * 4 + 2));
      @(negedge mclk);
      `CHK("dma_start", 1'b1, dma_start)
      `CHK("dma_unit", 2'(u), dma_unit)
      `CHK("dma_channel", 2'h2, dma_channel)
      @(posedge mclk);
    end
    wr(REG_BUSW, 32'h00000012);
    @(posedge mclk);
    wr(REG_PORTMODE, 32'h00000001);
    for (int a = 0; a < 8; a++) begin
      ext_access <= 1'b1;
      ext_area <= 3'(a);
      @(posedge mclk);
      ext_access <= 1'b0;
      @(negedge mclk);
      `CHK("ext_width16", (a == 1 || a > 3), ext_width16)
      @(posedge mclk);
    end
    `CHK("ext_hi_data_en", 1'b1, ext_hi_data_en)
    `CHK("port_mode", 8'h01, port_mode)
  endtask
  initial begin
    {reg_wr, reg_rd, nmi_line, sw_trap, illegal_op, ext_access} = 6'h00;
    {reg_addr, irq_lines, reg_wdata} = 48'h0;
    {op_arg, sw_trap_num, ext_area, op_kind} = 11'h000;
    do_reset();
    t_irq();
    t_prio();
    t_exc();
    t_io();
    wr(REG_SP, 32'h00001234);
    @(posedge mclk);
    wr(REG_STATUS, 32'h00007b00);
    rdchk(REG_STATUS, 32'h00007b00);
    do_reset();
    summarize();
  end
endmodule
`default_nettype wire
